// ### rtl/flash_host_pkg.sv
/*
  Constants and carrier types for the host-side flash command controller.
  Assumes a parallel NOR flash with strobe-latched command cycles.
*/
package flash_host_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam logic [7:0] CODE_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
  localparam logic [7:0] CODE_PROGRAM = 8'hA0;
  localparam logic [7:0] CODE_AUTOSEL = 8'h90;
  localparam logic [7:0] CODE_ERASE = 8'h80;
  localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CODE_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CODE_RESET = 8'hF0;
  localparam logic [19:0] ADDR_UNLOCK1_WORD = 20'h00555;
  localparam logic [19:0] ADDR_UNLOCK2_WORD = 20'h002AA;
  localparam logic [19:0] ADDR_UNLOCK1_BYTE = 20'h00AAA;
  localparam logic [19:0] ADDR_UNLOCK2_BYTE = 20'h00555;
  localparam int CLK_MHZ = 25;
  localparam int SETUP_NS = 80;
  localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_NS = 80;
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int WINDOW_US = 50;
  localparam int WINDOW_CYC = (WINDOW_US * CLK_MHZ) - 1;
  localparam logic [7:0] POLL_BIT = 8'h80;
  localparam logic [7:0] FAIL_BIT = 8'h20;

  typedef enum logic [2:0] {
    OP_RESET, OP_PROGRAM, OP_CHIP_ERASE, OP_SECTOR_ERASE,
    OP_ADD_SECTOR, OP_AUTOSELECT, OP_READ
  } op_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    op_type op;
  } req_type;

  typedef struct packed {
    logic chip_sel_n;
    logic write_n;
    logic output_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
  } pins_type;
endpackage : flash_host_pkg

// ### rtl/flash_host_ctrl.sv
/*
  Host controller that drives a parallel NOR flash through its strobes.
  Assumes the flash pins are wired to the pin struct and dq input; one clock.
*/
`timescale 1ns/1ps
module flash_host_ctrl #(
  parameter int WINDOW_CYCLES = flash_host_pkg::WINDOW_CYC
) (
  input wire logic sys_clk, // 25 MHz clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire flash_host_pkg::req_type req, // Requested operation
  input wire logic req_valid, // Request offered
  output logic req_ready, // Request taken this cycle
  input wire logic byte_mode, // Level of the width-select pin
  output logic done, // One-cycle pulse at operation end
  output logic failed, // Done with timing_failure_flag set
  output logic [flash_host_pkg::DATA_W-1:0] rd_data, // Read result
  output flash_host_pkg::pins_type pins, // Flash strobes, address, data
  input wire logic [flash_host_pkg::DATA_W-1:0] dq_in // Flash data pins
);
  import flash_host_pkg::*;

  typedef enum logic [2:0] {
    IDLE, SETUP, STROBE, HOLD, READ, POLL, POLL_GAP
  } state_type;

  typedef struct packed {
    state_type st;
    logic [3:0] step;
    logic [3:0] last;
    logic [7:0] cnt;
    logic [15:0] win;
    req_type r;
    logic poll;
    logic read_ok;
    pins_type p;
    logic done;
    logic failed;
    logic [DATA_W-1:0] rd;
    logic [DATA_W-1:0] s1;
    logic [DATA_W-1:0] s2;
    logic [DATA_W-1:0] s3;
  } all_type;

  all_type q, d;
  logic [ADDR_W-1:0] cyc_addr;
  logic [7:0] cyc_data;

  function automatic logic [ADDR_W-1:0] ul(input logic first,
                                           input logic bm);
    if (bm) begin
      ul = first ? ADDR_UNLOCK1_BYTE : ADDR_UNLOCK2_BYTE;
    end else begin
      ul = first ? ADDR_UNLOCK1_WORD : ADDR_UNLOCK2_WORD;
    end
  endfunction : ul

  // Address and data of command cycle number step of the sequence.
  always_comb begin
    cyc_addr = ul(1'b1, byte_mode);
    cyc_data = CODE_RESET;
    if (q.r.op != OP_RESET && q.r.op != OP_ADD_SECTOR) begin
      unique case (q.step)
        4'h0: cyc_data = CODE_UNLOCK1;
        4'h1: begin
          cyc_addr = ul(1'b0, byte_mode);
          cyc_data = CODE_UNLOCK2;
        end
        4'h2: begin
          if (q.r.op == OP_PROGRAM) cyc_data = CODE_PROGRAM;
          else if (q.r.op == OP_AUTOSELECT) cyc_data = CODE_AUTOSEL;
          else cyc_data = CODE_ERASE;
        end
        4'h3: begin
          if (q.r.op == OP_PROGRAM) begin
            cyc_addr = q.r.addr;
            cyc_data = q.r.data[7:0];
          end else begin
            cyc_data = CODE_UNLOCK1;
          end
        end
        4'h4: begin
          cyc_addr = ul(1'b0, byte_mode);
          cyc_data = CODE_UNLOCK2;
        end
        default: begin
          if (q.r.op == OP_CHIP_ERASE) begin
            cyc_data = CODE_CHIP_ERASE;
          end else begin
            cyc_addr = q.r.addr;
            cyc_data = CODE_SECTOR_ERASE;
          end
        end
      endcase
    end else if (q.r.op == OP_ADD_SECTOR) begin
      cyc_addr = q.r.addr;
      cyc_data = CODE_SECTOR_ERASE;
    end
  end

  always_comb begin
    d = q;
    d.done = 1'b0;
    d.failed = 1'b0;
    d.s1 = dq_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    req_ready = 1'b0;
    if (q.win != 16'h0) d.win = q.win - 16'h1;
    unique case (q.st)
      IDLE: begin
        d.p.chip_sel_n = 1'b1;
        d.p.write_n = 1'b1;
        d.p.output_n = 1'b1;
        d.p.dq_oe = 1'b0;
        // Adding a sector after the window closed is refused.
        if (req_valid && !(req.op == OP_ADD_SECTOR && q.win == 16'h0)) begin
          req_ready = 1'b1;
          d.r = req;
          d.step = 4'h0;
          d.cnt = 8'h0;
          d.st = (req.op == OP_READ) ? READ : SETUP;
          unique case (req.op)
            OP_RESET, OP_ADD_SECTOR: d.last = 4'h0;
            OP_PROGRAM, OP_AUTOSELECT: d.last = 4'h3;
            OP_CHIP_ERASE, OP_SECTOR_ERASE: d.last = 4'h5;
            default: d.last = 4'h0;
          endcase
          if (req.op == OP_AUTOSELECT) d.last = 4'h2;
          d.p.addr = req.addr;
          d.p.output_n = (req.op == OP_READ) ? 1'b0 : 1'b1;
          d.p.chip_sel_n = (req.op == OP_READ) ? 1'b0 : 1'b1;
        end
      end
      SETUP: begin
        // Address set up, then chip select and write fall together.
        d.p.addr = cyc_addr;
        d.p.dq_out = {{(DATA_W-8){1'b0}}, cyc_data};
        if (q.r.op == OP_PROGRAM && q.step == 4'h3) d.p.dq_out = q.r.data;
        d.p.dq_oe = 1'b1;
        d.cnt = q.cnt + 8'h1;
        // Pins were loaded on the first pass, so wait SETUP_CYC more.
        if (q.cnt == 8'(SETUP_CYC)) begin
          d.cnt = 8'h0;
          d.p.chip_sel_n = 1'b0;
          d.p.write_n = 1'b0;
          d.st = STROBE;
        end
      end
      STROBE: begin
        d.cnt = q.cnt + 8'h1;
        if (q.cnt == 8'(PULSE_CYC - 1)) begin
          d.cnt = 8'h0;
          d.p.write_n = 1'b1; // Data latched on this rising edge.
          d.st = HOLD;
        end
      end
      HOLD: begin
        d.p.chip_sel_n = 1'b1;
        d.p.dq_oe = 1'b0;
        if (q.step == q.last) begin
          d.step = 4'h0;
          if (q.r.op == OP_SECTOR_ERASE || q.r.op == OP_ADD_SECTOR) begin
            d.win = 16'(WINDOW_CYCLES);
            d.done = 1'b1;
            d.st = IDLE;
          end else if (q.r.op == OP_PROGRAM || q.r.op == OP_CHIP_ERASE) begin
            d.p.addr = q.r.addr;
            d.st = POLL_GAP;
          end else begin
            d.win = 16'h0;
            d.done = 1'b1;
            d.st = IDLE;
          end
        end else begin
          d.step = q.step + 4'h1;
          d.st = SETUP;
        end
      end
      POLL_GAP: begin
        d.p.chip_sel_n = 1'b1;
        d.p.output_n = 1'b1;
        d.cnt = q.cnt + 8'h1;
        if (q.cnt == 8'(SETUP_CYC + 2)) begin
          d.cnt = 8'h0;
          d.p.chip_sel_n = 1'b0;
          d.p.output_n = 1'b0;
          d.st = POLL;
        end
      end
      POLL: begin
        // Wait PULSE_CYC + 3 clocks of read access, then compare.
        d.cnt = q.cnt + 8'h1;
        // Only a value on which the last two stages agree is used.
        if (q.cnt >= 8'(PULSE_CYC + 3) && q.s2 == q.s3) begin
          d.cnt = 8'h0;
          d.st = POLL_GAP;
          d.p.chip_sel_n = 1'b1;
          d.p.output_n = 1'b1;
          // Erase reads bit 7 high once done; program reads its data bit.
          if (q.r.op == OP_CHIP_ERASE ? q.s3[7] :
              q.s3[7] == q.r.data[7]) begin
            d.done = 1'b1;
            d.st = IDLE;
          end else if (q.s3[5]) begin
            d.failed = 1'b1;
            d.done = 1'b1;
            d.st = IDLE;
          end
        end
      end
      READ: begin
        // Array read or autoselect read at the given address.
        d.cnt = q.cnt + 8'h1;
        if (q.cnt >= 8'(PULSE_CYC + 3) && q.s2 == q.s3) begin
          d.rd = q.s3;
          d.done = 1'b1;
          d.p.chip_sel_n = 1'b1;
          d.p.output_n = 1'b1;
          d.st = IDLE;
        end
      end
      default: d.st = IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.st <= IDLE;
      q.p.chip_sel_n <= 1'b1;
      q.p.write_n <= 1'b1;
      q.p.output_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign pins = q.p;
  assign done = q.done;
  assign failed = q.failed;
  assign rd_data = q.rd;
endmodule : flash_host_ctrl

// ### testbench/flash_host_ctrl_assertions.sv
/* Pin-timing checker for the flash host controller.
   Assumes binding to every flash_host_ctrl instance. */
`timescale 1ns/1ps
module flash_host_ctrl_assertions (
  input wire logic sys_clk, // Clock
  input wire logic reset_n, // Reset, active low
  input wire flash_host_pkg::req_type req, // Request
  input wire logic req_ready, // Request taken
  input wire logic done, // End pulse
  input wire logic failed, // Failure pulse
  input wire flash_host_pkg::pins_type pins // Flash pins
);
  import flash_host_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_wr_low; !pins.write_n ##1 !pins.write_n; endsequence
  sequence s_rst_wr; !pins.write_n && pins.dq_out[7:0] == CODE_RESET;
  endsequence
  property p_pulse; $fell(pins.write_n) |-> s_wr_low ##1 pins.write_n;
  endproperty
  a_pulse: assert property (p_pulse) else $error("bad write pulse");
  property p_setup; $rose(pins.dq_oe) |-> pins.write_n [*2]; endproperty
  a_setup: assert property (p_setup) else $error("short setup");
  property p_inh;
    !pins.write_n |-> !pins.chip_sel_n && pins.output_n && pins.dq_oe;
  endproperty
  a_inh: assert property (p_inh) else $error("bad strobes");
  property p_hold; !pins.write_n && $past(!pins.write_n) |->
    $stable(pins.addr) && $stable(pins.dq_out); endproperty
  a_hold: assert property (p_hold) else $error("pins moved");
  property p_rst; req_ready && req.op == OP_RESET |-> ##[2:4] s_rst_wr;
  endproperty
  a_rst: assert property (p_rst) else $error("no reset write");
  property p_busy; !pins.chip_sel_n |-> !req_ready; endproperty
  a_busy: assert property (p_busy) else $error("taken while busy");
  property p_fail; failed |-> done; endproperty
  a_fail: assert property (p_fail) else $error("failed alone");
  property p_done; done |=> !done; endproperty
  a_done: assert property (p_done) else $error("long done");
endmodule : flash_host_ctrl_assertions
bind flash_host_ctrl flash_host_ctrl_assertions flash_host_ctrl_assertions_i (
  .sys_clk, .reset_n, .req, .req_ready, .done, .failed, .pins);

// ### testbench/flash_dev_model.sv
/* Behavioural flash device: command decoder, busy timer, data array.
   Assumes pins as carried by pins_type; erased cells read all ones. */
`timescale 1ns/1ps
module flash_dev_model #(
  parameter logic [15:0] MAKER_ID = 16'h0011, // Arbitrary value.
  parameter logic [15:0] DEV_ID = 16'h2233, // Arbitrary value.
  parameter logic [15:0] CONT_ID = 16'h0044 // Arbitrary value.
) (
  input wire flash_host_pkg::pins_type pins, // Pins from the host
  input wire logic byte_mode, // Width-select level
  output wire logic [15:0] dq_in // Data toward the host
);
  import flash_host_pkg::*;
  logic [15:0] mem [logic [19:0]];
  logic [7:0] sq [$];
  logic [15:0] last = 16'h0;
  int st = 0, bsy = 0, win = 0;
  logic pb = 0;
  wire [11:0] a = pins.addr[11:0];
  wire [7:0] d = pins.dq_out[7:0];
  wire [11:0] u1 = byte_mode ? 12'hAAA : 12'h555;
  wire [11:0] u2 = byte_mode ? 12'h555 : 12'h2AA;
  function automatic logic [15:0] rd(logic [19:0] k);
    return mem.exists(k) ? mem[k] : 16'hFFFF;
  endfunction : rd
  always @(posedge pins.write_n) begin
    // Any other write inside the window drops the queued sectors.
    if (!pins.chip_sel_n && bsy == 0 && st == 8 && d != 8'h30) begin
      sq.delete();
      win = 0;
    end
    if (pins.chip_sel_n || bsy > 0) ;
    else if (st == 3) begin
      mem[pins.addr] = rd(pins.addr) & pins.dq_out;
      pb = pins.dq_out[7];
      bsy = 30;
      st = 0;
    end else if (d == 8'hF0) st = 0;
    else case (st)
      0, 4: st = a == u1 && d == 8'hAA ? st + 1 : 0;
      1, 5: st = a == u2 && d == 8'h55 ? st + 1 : 0;
      2: st = d == 8'h90 ? 7 : d == 8'hA0 ? 3 : d == 8'h80 ? 4 : 0;
      6, 8: if (d == 8'h10 && st == 6) begin
        mem.delete();
        pb = 1;
        bsy = 60;
        st = 0;
      end else if (d == 8'h30) begin
        sq.push_back(pins.addr[19:12]);
        pb = 1;
        win = 1250;
        st = 8;
      end else st = 0;
      default: st = st == 7 ? 7 : 0;
    endcase
  end
  always #40 begin
    if (bsy > 0) bsy--;
    if (win == 1) begin
      foreach (sq[i]) foreach (mem[k]) if (k[19:12] == sq[i]) mem[k] = '1;
      sq.delete();
      bsy = 60;
      st = 0;
    end
    if (win > 0) win--;
  end
  wire [15:0] rv = bsy > 0 || st == 8 ? {8'h0, ~pb, 7'h0}
    : st != 7 ? rd(pins.addr) : a[7:0] == 0 ? MAKER_ID
    : a[7:0] == 3 ? CONT_ID
    : a[7:0] == (byte_mode ? 8'h02 : 8'h01) ? DEV_ID : 16'h0;
  always @(posedge pins.output_n) last = rv;
  assign dq_in = !pins.chip_sel_n && !pins.output_n ? rv : ~last;
endmodule : flash_dev_model

// ### testbench/tb_top.sv
/* Self-checking bench: host controller against the flash device model.
   Assumes the model and checker files are compiled first. */
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_top;
  import flash_host_pkg::*;
  logic sys_clk = 0, reset_n = 0, req_valid = 0, byte_mode = 0;
  req_type req = '0;
  logic req_ready, done, failed;
  logic [15:0] rd_data, dq_in, a_d, b_d;
  logic [16:0] e, expq [$];
  logic [19:0] ad, bd;
  pins_type pins;
  int n_fail = 0, n_checks = 0;
  logic [15:0] ids [4] = '{16'h0011, 16'h2233, 16'h0, 16'h0044};
  always #20 sys_clk = ~sys_clk;
  flash_host_ctrl flash_host_ctrl_i (.sys_clk, .reset_n, .req, .req_valid,
    .req_ready, .byte_mode, .done, .failed, .rd_data, .pins, .dq_in);
  flash_dev_model flash_dev_model_i (.pins, .byte_mode, .dq_in);
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task automatic run(op_type op, logic [19:0] a, logic [15:0] d,
    logic c, logic [15:0] x);
    int i;
    req = '{a, d, op};
    req_valid = 1;
    expq.push_back({c, x});
    #1;
    for (i = 0; i < 3000 && !req_ready; i++) begin
      @(negedge sys_clk);
      #1;
    end
    @(negedge sys_clk);
    req_valid = 0;
    for (; i < 3000 && !done; i++) @(negedge sys_clk);
    if (i == 3000) begin n_fail++; give_verdict(); end
    @(negedge sys_clk);
  endtask : run
  always @(negedge sys_clk) if (done) begin
    e = expq.pop_front();
    if (e[16]) `CHK(rd_data, e[15:0])
    `CHK(failed, 1'b0)
  end
  initial begin
    void'($urandom(30824));
    ad = 20'($urandom);
    bd = ad ^ 20'h01000;
    a_d = 16'($urandom);
    b_d = 16'($urandom);
    b_d[7] = a_d[7];
    repeat (2) @(negedge sys_clk);
    reset_n = 1;
    run(OP_READ, ad, 0, 1, 16'hFFFF);
    run(OP_PROGRAM, ad, a_d, 0, 0);
    byte_mode = 1;
    run(OP_PROGRAM, ad, b_d, 0, 0);
    byte_mode = 0;
    run(OP_PROGRAM, bd, a_d, 0, 0);
    run(OP_READ, ad, 0, 1, a_d & b_d);
    run(OP_AUTOSELECT, bd, 0, 0, 0);
    for (int i = 0; i < 5; i++)
      run(OP_READ, {bd[19:8], 8'(i % 4)}, 0, 1, ids[i % 4]);
    run(OP_RESET, bd, 0, 0, 0);
    run(OP_SECTOR_ERASE, ad, 0, 0, 0);
    run(OP_RESET, 0, 0, 0, 0);
    repeat (1400) @(negedge sys_clk);
    run(OP_READ, ad, 0, 1, a_d & b_d);
    run(OP_SECTOR_ERASE, ad, 0, 0, 0);
    run(OP_ADD_SECTOR, bd, 0, 0, 0);
    run(OP_READ, ad, 0, 1, 16'h0);
    repeat (1400) @(negedge sys_clk);
    run(OP_READ, ad, 0, 1, 16'hFFFF);
    run(OP_READ, bd, 0, 1, 16'hFFFF);
    run(OP_PROGRAM, bd, b_d, 0, 0);
    run(OP_CHIP_ERASE, 0, 0, 0, 0);
    run(OP_READ, bd, 0, 1, 16'hFFFF);
    give_verdict();
  end
endmodule : tb_top
